// ---- core/sli_pkg.sv ----
package sli_pkg;
	localparam int          SLI_CLK_HZ        = 50000000;
	localparam int          SLI_FLASH_ON_MS   = 250;
	localparam int          SLI_FLASH_OFF_MS  = 250;
	localparam int          SLI_PAUSE_MS      = 1500;
	localparam int          SLI_BLANK_MS      = 500;
	localparam int          SLI_DMX_HOLD_MS   = 1000;
	localparam int          SLI_MOTOR_OFF_MS  = 2000;
	localparam int          SLI_FLASH_ON_CYC  = SLI_CLK_HZ / 1000 * SLI_FLASH_ON_MS;
	localparam int          SLI_FLASH_OFF_CYC = SLI_CLK_HZ / 1000 * SLI_FLASH_OFF_MS;
	localparam int          SLI_PAUSE_CYC     = SLI_CLK_HZ / 1000 * SLI_PAUSE_MS;
	localparam int          SLI_BLANK_CYC     = SLI_CLK_HZ / 1000 * SLI_BLANK_MS;
	localparam int          SLI_DMX_HOLD_CYC  = SLI_CLK_HZ / 1000 * SLI_DMX_HOLD_MS;
	localparam int          SLI_MOTOR_OFF_CYC = SLI_CLK_HZ / 1000 * SLI_MOTOR_OFF_MS;
	localparam int          SLI_NFAULT        = 11;
	localparam logic [3:0]  SLI_FW_VERSION    = 4'h3;
	localparam logic [31:0] SLI_REG_CTRL      = 32'h0000_0000;
	localparam logic [31:0] SLI_REG_STATUS    = 32'h0000_0004;
	localparam logic [31:0] SLI_REG_FAULT     = 32'h0000_0008;
	localparam logic [31:0] SLI_REG_FWVER     = 32'h0000_000c;
	localparam int          SLI_CTRL_DMX_BIT  = 0;
	localparam int          SLI_CTRL_PROD_BIT = 1;
	localparam int          SLI_CTRL_DATUM_BIT = 2;
	typedef enum logic [1:0] {
		SLI_LED_OFF   = 2'h0,
		SLI_LED_GREEN = 2'h1,
		SLI_LED_RED   = 2'h2
	} sli_led_t;
endpackage : sli_pkg

// ---- core/sli_flash_seq.sv ----
`timescale 1ns/10ps
module sli_flash_seq #(
	parameter int ON_CYC    = 16,
	parameter int OFF_CYC   = 16,
	parameter int PAUSE_CYC = 64
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       start,
	input  wire logic [3:0] count,
	output logic            busy,
	output logic            lit
);
	import sli_pkg::*;
	typedef enum logic [1:0] {
		SLI_FS_IDLE  = 2'b00,
		SLI_FS_ON    = 2'b01,
		SLI_FS_OFF   = 2'b11,
		SLI_FS_PAUSE = 2'b10
	} sli_fs_state_t;
	typedef struct packed {
		sli_fs_state_t st;
		logic [31:0]   tmr;
		logic [3:0]    left;
	} sli_fs_t;
	sli_fs_t s_ff;
	sli_fs_t nxt_s;

	always_comb begin
		nxt_s = s_ff;
		case (s_ff.st)
			SLI_FS_IDLE: begin
				if (start && count != 4'h0) begin
					nxt_s.st   = SLI_FS_ON;
					nxt_s.left = count;
					nxt_s.tmr  = 32'(ON_CYC - 1);
				end
			end
			SLI_FS_ON: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.st   = SLI_FS_OFF;
					nxt_s.left = s_ff.left - 4'h1;
					nxt_s.tmr  = 32'(OFF_CYC - 1);
				end else begin
					nxt_s.tmr = s_ff.tmr - 32'h1;
				end
			end
			SLI_FS_OFF: begin
				if (s_ff.tmr == 32'h0) begin
					if (s_ff.left == 4'h0) begin
						nxt_s.st  = SLI_FS_PAUSE;
						nxt_s.tmr = 32'(PAUSE_CYC - 1);
					end else begin
						nxt_s.st  = SLI_FS_ON;
						nxt_s.tmr = 32'(ON_CYC - 1);
					end
				end else begin
					nxt_s.tmr = s_ff.tmr - 32'h1;
				end
			end
			default: begin
				if (s_ff.tmr == 32'h0) begin
					nxt_s.st = SLI_FS_IDLE;
				end else begin
					nxt_s.tmr = s_ff.tmr - 32'h1;
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '{st: SLI_FS_IDLE, tmr: 32'h0, left: 4'h0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign busy = (s_ff.st != SLI_FS_IDLE);
	assign lit  = (s_ff.st == SLI_FS_ON);
endmodule : sli_flash_seq

// ---- core/sli_ahb_regs.sv ----
`timescale 1ns/10ps
module sli_ahb_regs (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] status_in,
	input  wire logic [31:0] fault_in,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [2:0]       ctrl
);
	import sli_pkg::*;
	typedef struct packed {
		logic        wr_pend;
		logic [31:0] addr;
		logic [2:0]  ctrl;
		logic [31:0] rdata;
	} sli_ahb_t;
	sli_ahb_t s_ff;
	sli_ahb_t nxt_s;
	logic     take;

	always_comb begin
		nxt_s = s_ff;
		take  = hsel && hready && htrans[1];
		if (s_ff.wr_pend && s_ff.addr == SLI_REG_CTRL) begin
			nxt_s.ctrl = hwdata[2:0];
		end
		nxt_s.wr_pend = take && hwrite;
		if (take) begin
			nxt_s.addr = {haddr[31:2], 2'b00};
		end
		if (take && !hwrite) begin
			if (haddr[31:2] == SLI_REG_CTRL[31:2]) begin
				nxt_s.rdata = {29'h0, nxt_s.ctrl};
			end else if (haddr[31:2] == SLI_REG_STATUS[31:2]) begin
				nxt_s.rdata = status_in;
			end else if (haddr[31:2] == SLI_REG_FAULT[31:2]) begin
				nxt_s.rdata = fault_in;
			end else if (haddr[31:2] == SLI_REG_FWVER[31:2]) begin
				nxt_s.rdata = {28'h0, SLI_FW_VERSION};
			end else begin
				nxt_s.rdata = 32'h0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '{wr_pend: 1'b0, addr: 32'h0, ctrl: 3'h0, rdata: 32'h0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hrdata    = s_ff.rdata;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ctrl      = s_ff.ctrl;
	logic unused_ok;
	assign unused_ok = ^hsize;
endmodule : sli_ahb_regs

// ---- core/sli_status_led.sv ----
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
// Contract
// - At power-up blink green as many times as the firmware version.
// - Host-bus control with no fault shows steady green.
// - A valid host-bus frame outside a blanking window blanks the LED briefly, then green again.
// - Continuous host-bus frames make repeated blanking look like slow blink.
// - DMX mode: slow green blink with data present, steady green without.
// - Any fault overrides green once the version blink has ended; red blinks equal to the fault code.
// - Several faults: each red sequence in turn, pause between sequences.
// - Pan limit is code 1, tilt limit code 2, even in normal travel.
// - Motor over-current codes 3-5 disable motor a while; code latches until power off.
// - Panel supply over-current code 6 turns output off until power cycle.
// - Heater over-current code 7 turns heater off until power cycle.
// - Bad limit input for product is code 8; failed datum is code 9.
// - Product type unset or corrupt is code 10; supply out of window code 11.
module sli_status_led
	import sli_pkg::*;
#(
	parameter int FLASH_ON_CYC  = SLI_FLASH_ON_CYC,
	parameter int FLASH_OFF_CYC = SLI_FLASH_OFF_CYC,
	parameter int PAUSE_CYC     = SLI_PAUSE_CYC,
	parameter int BLANK_CYC     = SLI_BLANK_CYC,
	parameter int DMX_HOLD_CYC  = SLI_DMX_HOLD_CYC,
	parameter int MOTOR_OFF_CYC = SLI_MOTOR_OFF_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        pan_limit,
	input  wire logic        tilt_limit,
	input  wire logic [2:0]  motor_oc,
	input  wire logic        panel_oc,
	input  wire logic        heater_oc,
	input  wire logic        limit_invalid,
	input  wire logic        supply_bad,
	input  wire logic        host_frame_ok,
	input  wire logic        dmx_frame_ok,
	output logic             led_green,
	output logic             led_red,
	output logic [2:0]       motor_en,
	output logic             panel_pwr_en,
	output logic             heater_en
);
	import sli_pkg::*;

	typedef enum logic [1:0] {
		SLI_M_VERSION = 2'b00,
		SLI_M_NORMAL  = 2'b01,
		SLI_M_FAULT   = 2'b11
	} sli_mode_t;

	typedef struct packed {
		sli_mode_t   mode;
		logic        started;
		logic [2:0]  motor_lat;
		logic [2:0]  motor_en;
		logic [95:0] motor_tmr;
		logic        panel_lat;
		logic        heater_lat;
		logic [31:0] blank_tmr;
		logic [31:0] dmx_tmr;
		logic [31:0] slow_tmr;
		logic        slow_ph;
		logic [3:0]  cur_code;
		logic        green;
		logic        red;
	} sli_top_t;

	sli_top_t     s_ff;
	sli_top_t     nxt_s;
	logic [2:0]   ctrl;
	logic [10:0]  fault_vec;
	logic         fs_start;
	logic [3:0]   fs_count;
	logic         fs_busy;
	logic         fs_lit;
	logic [3:0]   next_code;
	logic [31:0]  status_word;
	logic [31:0]  fault_word;

	sli_ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.status_in (status_word),
		.fault_in  (fault_word),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.ctrl      (ctrl)
	);

	sli_flash_seq #(
		.ON_CYC    (FLASH_ON_CYC),
		.OFF_CYC   (FLASH_OFF_CYC),
		.PAUSE_CYC (PAUSE_CYC)
	) u_seq (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (fs_start),
		.count   (fs_count),
		.busy    (fs_busy),
		.lit     (fs_lit)
	);

	// Fault bit n means code n+1
	assign fault_vec[0]   = pan_limit;
	assign fault_vec[1]   = tilt_limit;
	assign fault_vec[4:2] = s_ff.motor_lat;
	assign fault_vec[5]   = s_ff.panel_lat;
	assign fault_vec[6]   = s_ff.heater_lat;
	assign fault_vec[7]   = limit_invalid;
	assign fault_vec[8]   = ctrl[SLI_CTRL_DATUM_BIT];
	assign fault_vec[9]   = ctrl[SLI_CTRL_PROD_BIT];
	assign fault_vec[10]  = supply_bad;

	assign status_word = {24'h0, s_ff.cur_code, 1'b0, s_ff.red, s_ff.green, s_ff.mode == SLI_M_FAULT};
	assign fault_word  = {21'h0, fault_vec};

	// Next active code after the current one, wrapping round
	always_comb begin
		next_code = 4'h0;
		for (int i = SLI_NFAULT - 1; i >= 0; i--) begin
			if (fault_vec[i] && 4'(i + 1) > s_ff.cur_code) begin
				next_code = 4'(i + 1);
			end
		end
		if (next_code == 4'h0) begin
			for (int i = SLI_NFAULT - 1; i >= 0; i--) begin
				if (fault_vec[i]) begin
					next_code = 4'(i + 1);
				end
			end
		end
	end

	always_comb begin
		nxt_s    = s_ff;
		fs_start = 1'b0;
		fs_count = 4'h0;
		nxt_s.started = 1'b1;
		// Over-current latches; set wins, only reset clears
		for (int m = 0; m < 3; m++) begin
			if (motor_oc[m]) begin
				nxt_s.motor_lat[m] = 1'b1;
				nxt_s.motor_en[m]  = 1'b0;
				nxt_s.motor_tmr[m*32 +: 32] = 32'(MOTOR_OFF_CYC - 1);
			end else if (!s_ff.motor_en[m]) begin
				if (s_ff.motor_tmr[m*32 +: 32] == 32'h0) begin
					nxt_s.motor_en[m] = 1'b1;
				end else begin
					nxt_s.motor_tmr[m*32 +: 32] = s_ff.motor_tmr[m*32 +: 32] - 32'h1;
				end
			end
		end
		if (panel_oc) begin
			nxt_s.panel_lat = 1'b1;
		end
		if (heater_oc) begin
			nxt_s.heater_lat = 1'b1;
		end
		// Host frame blanking, started only when no window runs; frames inside a window are ignored
		if (host_frame_ok && s_ff.blank_tmr == 32'h0) begin
			nxt_s.blank_tmr = 32'(BLANK_CYC + BLANK_CYC - 1);
		end else if (s_ff.blank_tmr != 32'h0) begin
			nxt_s.blank_tmr = s_ff.blank_tmr - 32'h1;
		end
		// DMX presence and slow blink timebase
		if (dmx_frame_ok) begin
			nxt_s.dmx_tmr = 32'(DMX_HOLD_CYC);
		end else if (s_ff.dmx_tmr != 32'h0) begin
			nxt_s.dmx_tmr = s_ff.dmx_tmr - 32'h1;
		end
		if (s_ff.slow_tmr == 32'h0) begin
			nxt_s.slow_tmr = 32'(BLANK_CYC - 1);
			nxt_s.slow_ph  = !s_ff.slow_ph;
		end else begin
			nxt_s.slow_tmr = s_ff.slow_tmr - 32'h1;
		end
		case (s_ff.mode)
			SLI_M_VERSION: begin
				if (!s_ff.started) begin
					fs_start = 1'b1;
					fs_count = SLI_FW_VERSION;
				end else if (!fs_busy) begin
					nxt_s.mode = SLI_M_NORMAL;
				end
				nxt_s.green = fs_lit;
				nxt_s.red   = 1'b0;
			end
			SLI_M_NORMAL: begin
				nxt_s.red = 1'b0;
				if (|fault_vec) begin
					nxt_s.mode  = SLI_M_FAULT;
					nxt_s.green = 1'b0;
				end else if (ctrl[SLI_CTRL_DMX_BIT]) begin
					nxt_s.green = (s_ff.dmx_tmr == 32'h0) || s_ff.slow_ph;
				end else begin
					// Blank for the first half of the window
					nxt_s.green = (s_ff.blank_tmr < 32'(BLANK_CYC));
				end
			end
			default: begin
				nxt_s.green = 1'b0;
				nxt_s.red   = fs_lit;
				if (!fs_busy && !fs_start) begin
					if (|fault_vec) begin
						fs_start       = 1'b1;
						fs_count       = next_code;
						nxt_s.cur_code = next_code;
					end else begin
						nxt_s.mode     = SLI_M_NORMAL;
						nxt_s.cur_code = 4'h0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '{mode: SLI_M_VERSION, started: 1'b0, motor_lat: 3'h0, motor_en: 3'h7,
				motor_tmr: 96'h0, panel_lat: 1'b0, heater_lat: 1'b0, blank_tmr: 32'h0,
				dmx_tmr: 32'h0, slow_tmr: 32'h0, slow_ph: 1'b0, cur_code: 4'h0,
				green: 1'b0, red: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign led_green    = s_ff.green;
	assign led_red      = s_ff.red;
	assign motor_en     = s_ff.motor_en;
	assign panel_pwr_en = !s_ff.panel_lat;
	assign heater_en    = !s_ff.heater_lat;
endmodule : sli_status_led

// ---- tb/sli_status_led_checker.sv ----
`timescale 1ns/10ps
module sli_status_led_checker (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       hsel,
	input wire logic [1:0] htrans,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic       pan_limit,
	input wire logic       supply_bad,
	input wire logic [2:0] motor_oc,
	input wire logic       panel_oc,
	input wire logic       heater_oc,
	input wire logic       led_green,
	input wire logic       led_red,
	input wire logic [2:0] motor_en,
	input wire logic       panel_pwr_en,
	input wire logic       heater_en
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_pan_held;
		pan_limit [*4];
	endsequence
	sequence s_motor_off;
		!motor_en[1] [*8];
	endsequence
	AST_LED_EXCL: assert property (!(led_green && led_red))
		else $error("green and red lit together");
	AST_PAN_NO_GREEN: assert property (s_pan_held |-> !led_green)
		else $error("green shown during limit fault");
	AST_SUPPLY_NO_GREEN: assert property (supply_bad [*4] |-> !led_green)
		else $error("green shown during supply fault");
	AST_MOTOR_DROP: assert property (motor_oc[0] |=> !motor_en[0])
		else $error("motor not disabled on over-current");
	AST_MOTOR_HOLD: assert property ($fell(motor_oc[1]) && !motor_en[1] |-> s_motor_off)
		else $error("motor re-enabled too soon");
	AST_PANEL_DROP: assert property (panel_oc |=> !panel_pwr_en)
		else $error("panel supply not switched off");
	AST_PANEL_LATCH: assert property (!panel_pwr_en |=> !panel_pwr_en)
		else $error("panel supply restored without reset");
	AST_HEATER_DROP: assert property (heater_oc |=> !heater_en)
		else $error("heater not switched off");
	AST_HEATER_LATCH: assert property (!heater_en |=> $stable(heater_en))
		else $error("heater restored without reset");
	AST_BUS_OKAY: assert property (hsel && htrans[1] |=> hreadyout && !hresp)
		else $error("bus response not zero-wait okay");
endmodule : sli_status_led_checker

bind sli_status_led sli_status_led_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hreadyout(hreadyout), .hresp(hresp), .pan_limit(pan_limit),
	.supply_bad(supply_bad), .motor_oc(motor_oc), .panel_oc(panel_oc), .heater_oc(heater_oc),
	.led_green(led_green), .led_red(led_red), .motor_en(motor_en),
	.panel_pwr_en(panel_pwr_en), .heater_en(heater_en));

// ---- tb/sli_sensor_model.sv ----
`timescale 1ns/10ps
module sli_sensor_model #(
	parameter int GAP = 5
) (
	input  wire logic       hclk,
	input  wire logic [8:0] req,
	input  wire logic       host_en,
	input  wire logic       dmx_en,
	output wire logic       pan_limit,
	output wire logic       tilt_limit,
	output wire logic [2:0] motor_oc,
	output wire logic       panel_oc,
	output wire logic       heater_oc,
	output wire logic       limit_invalid,
	output wire logic       supply_bad,
	output logic            host_frame_ok,
	output logic            dmx_frame_ok
);
	logic [7:0] cnt;
	// Sensor flags follow the requested fault pattern
	assign {supply_bad, limit_invalid, heater_oc, panel_oc, motor_oc, tilt_limit, pan_limit} = req;
	initial begin
		cnt = 8'h0;
		host_frame_ok = 1'b0;
		dmx_frame_ok = 1'b0;
	end
	// Receivers strobe one valid frame every GAP cycles while traffic runs
	always @(posedge hclk) begin
		host_frame_ok <= host_en && cnt == 8'h0;
		dmx_frame_ok <= dmx_en && cnt == 8'h0;
		cnt <= (host_en || dmx_en) && cnt < 8'(GAP - 1) ? cnt + 8'h1 : 8'h0;
	end
endmodule : sli_sensor_model

// ---- tb/sli_status_led_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module sli_status_led_tb;
	import sli_pkg::*;
	localparam int BLANK = 8;
	localparam int HOLD = 32;
	localparam int MOFF = 16;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, host_en, dmx_en;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, motor_oc, motor_en;
	logic [8:0]  req;
	logic        pan_limit, tilt_limit, panel_oc, heater_oc, limit_invalid, supply_bad;
	logic        host_frame_ok, dmx_frame_ok, led_green, led_red, panel_pwr_en, heater_en;
	int          n_errors, checked, n, a, b, f;
	sli_status_led #(.FLASH_ON_CYC(4), .FLASH_OFF_CYC(4), .PAUSE_CYC(16), .BLANK_CYC(BLANK),
		.DMX_HOLD_CYC(HOLD), .MOTOR_OFF_CYC(MOFF)) dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pan_limit(pan_limit), .tilt_limit(tilt_limit), .motor_oc(motor_oc),
		.panel_oc(panel_oc), .heater_oc(heater_oc), .limit_invalid(limit_invalid),
		.supply_bad(supply_bad), .host_frame_ok(host_frame_ok), .dmx_frame_ok(dmx_frame_ok),
		.led_green(led_green), .led_red(led_red), .motor_en(motor_en),
		.panel_pwr_en(panel_pwr_en), .heater_en(heater_en));
	sli_sensor_model #(.GAP(5)) u_sens (.hclk(hclk), .req(req), .host_en(host_en),
		.dmx_en(dmx_en), .pan_limit(pan_limit), .tilt_limit(tilt_limit), .motor_oc(motor_oc),
		.panel_oc(panel_oc), .heater_oc(heater_oc), .limit_invalid(limit_invalid),
		.supply_bad(supply_bad), .host_frame_ok(host_frame_ok), .dmx_frame_ok(dmx_frame_ok));
	task automatic rw(input bit wr, input logic [31:0] ad, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : rw
	// Counts short flashes; stops on a steady lit run or on a pause after flashes
	task automatic pulses(input bit red, output int cnt);
		int hi, lo;
		cnt = 0;
		hi = 0;
		lo = 0;
		repeat (400) begin
			@(posedge hclk);
			#1;
			if ((red ? led_red : led_green) === 1'b1) begin
				hi++;
				lo = 0;
				if (hi >= 10) break;
			end else begin
				if (hi > 0) cnt++;
				hi = 0;
				lo++;
				if (cnt > 0 && lo >= 10) break;
			end
		end
	endtask : pulses
	task automatic quiet();
		int lo;
		lo = 0;
		repeat (400) begin
			@(posedge hclk);
			lo = led_red === 1'b1 ? 0 : lo + 1;
			if (lo >= 10) break;
		end
	endtask : quiet
	task automatic falls(input int cyc, output int cnt);
		logic prev;
		cnt = 0;
		prev = led_green;
		repeat (cyc) begin
			@(posedge hclk);
			#1;
			if (prev === 1'b1 && led_green === 1'b0) cnt++;
			prev = led_green;
		end
	endtask : falls
	task automatic set(input int c, input bit v);
		if (c == 9 || c == 10) rw(1'b1, SLI_REG_CTRL, {29'h0, v && c == 9, v && c == 10, 1'b0});
		else req[c == 11 ? 8 : c - 1] <= v;
	endtask : set
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	initial begin
		repeat (40000) @(posedge hclk);
		n_errors++;
		report_and_stop();
	end
	initial begin
		{hresetn, hsel, hwrite, host_en, dmx_en, haddr, hwdata, htrans, req} = '0;
		hsize = 3'h2;
		n_errors = 0;
		checked = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		pulses(1'b0, n);
		`CHK("version flashes", 32'(SLI_FW_VERSION), n)
		rw(1'b0, SLI_REG_FWVER, 32'h0);
		`CHK("version reg", {28'h0, SLI_FW_VERSION}, rd)
		`CHK("bus resp", 1'b0, hresp)
		rw(1'b0, 32'h10, 32'h0);
		`CHK("unmapped reg", 32'h0, rd)
		falls(30, f);
		`CHK("steady green", 0, f)
		host_en <= 1'b1;
		@(posedge hclk);
		host_en <= 1'b0;
		falls(40, f);
		`CHK("one frame blank", 1, f)
		`CHK("green back", 1'b1, led_green)
		host_en <= 1'b1;
		falls(120, f);
		host_en <= 1'b0;
		`CHK("host slow blink", 1, int'(f >= 3))
		$display("test host done");
		rw(1'b1, SLI_REG_CTRL, 32'h1);
		rw(1'b0, SLI_REG_CTRL, 32'h0);
		`CHK("ctrl reg", 32'h1, rd)
		falls(40, f);
		`CHK("dmx idle steady", 0, f)
		dmx_en <= 1'b1;
		falls(100, f);
		dmx_en <= 1'b0;
		`CHK("dmx slow blink", 1, int'(f >= 3))
		repeat (HOLD + 2 * BLANK) @(posedge hclk);
		falls(40, f);
		`CHK("dmx lost steady", 0, f)
		rw(1'b1, SLI_REG_CTRL, 32'h0);
		$display("test dmx done");
		for (int c = 1; c <= 11; c++) begin
			set(c, 1'b1);
			quiet();
			pulses(1'b1, n);
			`CHK("red flashes", c, n)
			rw(1'b0, SLI_REG_STATUS, 32'h0);
			`CHK("status reg", {24'h0, 4'(c), 4'h1}, rd)
			rw(1'b0, SLI_REG_FAULT, 32'h0);
			`CHK("fault reg", 32'h1 << (c - 1), rd)
			set(c, 1'b0);
			repeat (4) @(posedge hclk);
			if (c >= 3 && c <= 7) begin
				rw(1'b0, SLI_REG_FAULT, 32'h0);
				`CHK("fault latched", 32'h1 << (c - 1), rd)
				repeat (MOFF + 4) @(posedge hclk);
				`CHK("motors back", 3'h7, motor_en)
				`CHK("outputs", {c != 6, c != 7}, {panel_pwr_en, heater_en})
				hresetn <= 1'b0;
				@(posedge hclk);
				hresetn <= 1'b1;
				pulses(1'b0, n);
				`CHK("version after reset", 32'(SLI_FW_VERSION), n)
			end
			$display("test fault code %0d done", c);
		end
		req <= 9'h3;
		quiet();
		pulses(1'b1, a);
		pulses(1'b1, b);
		req <= 9'h0;
		`CHK("two codes total", 3, a + b)
		`CHK("codes differ", 1, int'(a != b))
		$display("test multi fault done");
		report_and_stop();
	end
endmodule : sli_status_led_tb
